// ---- core/ncarp_defines.svh ----
/*
  Timing counts, opcodes and address layout for the flash host sequencer.
  Assumes a 25 MHz system clock; included by the host design only.
*/
`ifndef NCARP_DEFINES_SVH
`define NCARP_DEFINES_SVH

// Clock period in ns
`define NCARP_CLK_NS        40
// Strobe phase times in ns, each rounded up to whole cycles
`define NCARP_T_SETUP_NS    40
`define NCARP_T_SETUP_CYC   ((`NCARP_T_SETUP_NS + `NCARP_CLK_NS - 1) / `NCARP_CLK_NS)
`define NCARP_T_PULSE_NS    40
`define NCARP_T_PULSE_CYC   ((`NCARP_T_PULSE_NS + `NCARP_CLK_NS - 1) / `NCARP_CLK_NS)
`define NCARP_T_HOLD_NS     40
`define NCARP_T_HOLD_CYC    ((`NCARP_T_HOLD_NS + `NCARP_CLK_NS - 1) / `NCARP_CLK_NS)
// Wait after the confirm before sampling ready/busy
`define NCARP_T_WB_NS       120
`define NCARP_T_WB_CYC      ((`NCARP_T_WB_NS + `NCARP_CLK_NS - 1) / `NCARP_CLK_NS)

// Opcodes
`define NCARP_OP_READ       8'h00
`define NCARP_OP_READ_GO    8'h30
`define NCARP_OP_RESET      8'hFF

// Page geometry
`define NCARP_PAGE_BYTES    12'h0880
`define NCARP_PAGE_LAST     12'h087F
`define NCARP_ADDR_CYCLES   3'h5

`endif

// ---- core/ncarp_pkg.sv ----
/*
  Types shared by the flash host sequencer.
  Assumes ncarp_defines.svh sits on the include path.
*/
package ncarp_pkg;
  // Sequencer states
  typedef enum logic [3:0] {
    NCARP_IDLE,
    NCARP_CMD,
    NCARP_ADDR,
    NCARP_CONFIRM,
    NCARP_WAIT_WB,
    NCARP_WAIT_RDY,
    NCARP_READ,
    NCARP_READ_HOLD,
    NCARP_PUSH
  } ncarp_state_t;

  // Strobe phase within one port cycle
  typedef enum logic [1:0] {
    NCARP_PH_SETUP,
    NCARP_PH_PULSE,
    NCARP_PH_HOLD
  } ncarp_phase_t;
endpackage : ncarp_pkg

// ---- core/ncarp_host.sv ----
/*
  Host-side page read sequencer for an asynchronous 8-bit page flash.
  Takes a read request (block, page, start column, byte count), issues the
  read opcode, five address cycles and the confirm, waits out busy, then
  strobes bytes out through a two-entry buffer to the user.
  Assumes the board pulls ready/busy high and resolves the data pins from
  the output enable (active low).
*/
// Notes on behaviour
// - Commands, addresses and data all travel on one eight-bit two-way port.
// - A full address takes five consecutive address latch cycles.
// - Column goes in cycles one and two, low first, top nibble zero.
// - Row goes in cycles three to five; only bit 0 of cycle five used.
// - Command, address and data entry use their own latch and strobe levels.
// - During read busy with select low, both strobes stay high.
// - Page read is 00h then 30h; other read opcodes exist.
// - Program opcodes: 80h load, 10h or 15h confirm, 11h/81h multi.
// - Opcode 85h moves the column during program data loading.
// - Copy opcodes: 00h-3Ah, 8Ch-15h, 8Ch-10h.
// - Erase is 60h then D0h; identification read is 90h.
`timescale 1ns/10ps
`default_nettype none
`include "ncarp_defines.svh"

module ncarp_host
  import ncarp_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  // Read request from user
  input  wire logic        req_valid_in,
  output logic             req_ready_out,
  input  wire logic [10:0] req_block_in,
  input  wire logic [5:0]  req_page_in,
  input  wire logic [11:0] req_column_in,
  input  wire logic [11:0] req_count_in,
  // Read data to user
  output logic             rd_valid_out,
  input  wire logic        rd_ready_in,
  output logic [7:0]       rd_data_out,
  output logic             busy_out,
  // Flash pins
  output logic             chip_sel_n_out,
  output logic             cmd_latch_out,
  output logic             addr_latch_out,
  output logic             write_strobe_n_out,
  output logic             read_strobe_n_out,
  output logic             prog_guard_n_out,
  input  wire logic        ready_busy_n_in,
  input  wire logic [7:0]  io_in,
  output logic [7:0]       io_out,
  output logic             io_oe_b_out
);

  // Sequencer registers
  ncarp_state_t state_q, state_d;
  ncarp_phase_t phase_q;
  logic [2:0]   tcnt_q;
  logic [2:0]   acyc_q;
  logic [11:0]  remain_q;
  logic [11:0]  column_q;
  logic [39:0]  addr_q;
  logic [7:0]   cap_q;
  logic         first_q;

  // Ready/busy synchroniser: pin is asynchronous to clk_in
  logic rb_s1_q, rb_s2_q, rb_s3_q, rb_ready_q;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rb_s1_q    <= 1'b0;
      rb_s2_q    <= 1'b0;
      rb_s3_q    <= 1'b0;
      rb_ready_q <= 1'b0;
    end else begin
      rb_s1_q <= ready_busy_n_in;
      rb_s2_q <= rb_s1_q;
      rb_s3_q <= rb_s2_q;
      if (rb_s2_q == rb_s3_q) begin
        rb_ready_q <= rb_s3_q;
      end
    end
  end

  // Two-entry output buffer; a stalled reader holds the read strobe
  logic [7:0] buf_mem [0:1];
  logic       buf_wp_q, buf_rp_q;
  logic [1:0] buf_cnt_q;
  wire        buf_push  = (state_q == NCARP_PUSH);
  wire        buf_pop   = rd_valid_out && rd_ready_in;
  wire        buf_full  = (buf_cnt_q == 2'd2);
  wire        buf_empty = (buf_cnt_q == 2'd0);
  assign rd_valid_out = !buf_empty;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      buf_wp_q  <= 1'b0;
      buf_rp_q  <= 1'b0;
      buf_cnt_q <= 2'd0;
      rd_data_out <= 8'h00;
    end else begin
      if (buf_push) begin
        buf_wp_q <= ~buf_wp_q;
      end
      if (buf_pop) begin
        buf_rp_q <= ~buf_rp_q;
      end
      buf_cnt_q <= buf_cnt_q + {1'b0, buf_push} - {1'b0, buf_pop};
      rd_data_out <= buf_mem[buf_pop ? ~buf_rp_q : buf_rp_q];
      if (buf_push && (buf_empty || (buf_pop && buf_cnt_q == 2'd1))) begin
        rd_data_out <= cap_q;
      end
    end
  end

  // Buffer storage carries no reset
  always_ff @(posedge clk_in) begin
    if (buf_push) begin
      buf_mem[buf_wp_q] <= cap_q;
    end
  end

  // Phase timing for one strobed port cycle
  wire strobe_state = (state_q == NCARP_CMD) || (state_q == NCARP_ADDR)
                   || (state_q == NCARP_CONFIRM);
  wire [2:0] phase_len = (phase_q == NCARP_PH_SETUP) ? 3'(`NCARP_T_SETUP_CYC)
                       : (phase_q == NCARP_PH_PULSE) ? 3'(`NCARP_T_PULSE_CYC)
                       : 3'(`NCARP_T_HOLD_CYC);
  wire phase_end = (tcnt_q + 3'd1 >= phase_len);
  wire cycle_end = phase_end && (phase_q == NCARP_PH_HOLD);
  wire last_byte = (remain_q == 12'd1)
                || (column_q == `NCARP_PAGE_LAST);

  // Address bytes: column low first, top nibble and cycle five bits 7:1 padded low
  wire [39:0] addr_pack = {7'h00, req_block_in[10],
                           req_block_in[9:0], req_page_in,
                           4'h0, req_column_in};

  // Next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      NCARP_IDLE: begin
        if (req_valid_in) begin
          state_d = NCARP_CMD;
        end
      end
      NCARP_CMD: begin
        if (cycle_end) begin
          state_d = NCARP_ADDR;
        end
      end
      NCARP_ADDR: begin
        if (cycle_end && acyc_q == `NCARP_ADDR_CYCLES - 3'd1) begin
          state_d = NCARP_CONFIRM;
        end
      end
      NCARP_CONFIRM: begin
        if (cycle_end) begin
          state_d = NCARP_WAIT_WB;
        end
      end
      NCARP_WAIT_WB: begin
        if (tcnt_q + 3'd1 >= 3'(`NCARP_T_WB_CYC)) begin
          state_d = NCARP_WAIT_RDY;
        end
      end
      NCARP_WAIT_RDY: begin
        // An empty count still runs the sequence but strobes nothing out
        if (rb_ready_q) begin
          state_d = (remain_q == 12'd0) ? NCARP_IDLE : NCARP_READ;
        end
      end
      NCARP_READ: begin
        if (!buf_full && phase_end) begin
          state_d = NCARP_READ_HOLD;
        end
      end
      NCARP_READ_HOLD: begin
        if (phase_end) begin
          state_d = NCARP_PUSH;
        end
      end
      NCARP_PUSH: begin
        state_d = (last_byte || remain_q == 12'd0) ? NCARP_IDLE : NCARP_READ;
      end
    endcase
  end

  // Sequencer registers update
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q  <= NCARP_IDLE;
      phase_q  <= NCARP_PH_SETUP;
      tcnt_q   <= 3'd0;
      acyc_q   <= 3'd0;
      remain_q <= 12'd0;
      column_q <= 12'd0;
      addr_q   <= 40'h00_0000_0000;
      cap_q    <= 8'h00;
      first_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      // The busy wait keeps counting; the strobe phases restart per phase
      tcnt_q  <= (state_d != state_q
                  || (phase_end && state_q != NCARP_WAIT_WB))
               ? 3'd0 : tcnt_q + 3'd1;
      if (strobe_state && phase_end) begin
        phase_q <= (phase_q == NCARP_PH_HOLD) ? NCARP_PH_SETUP
                 : (phase_q == NCARP_PH_SETUP) ? NCARP_PH_PULSE
                 : NCARP_PH_HOLD;
      end
      if (state_q == NCARP_IDLE && req_valid_in) begin
        addr_q   <= addr_pack;
        column_q <= req_column_in;
        remain_q <= req_count_in;
        acyc_q   <= 3'd0;
        phase_q  <= NCARP_PH_SETUP;
      end
      if (state_q == NCARP_ADDR && cycle_end) begin
        addr_q <= {8'h00, addr_q[39:8]};
        acyc_q <= acyc_q + 3'd1;
      end
      first_q <= (state_q == NCARP_WAIT_RDY);
      if (state_q == NCARP_READ && phase_end && !buf_full) begin
        cap_q <= io_in; // Sampled at the end of the low phase
      end
      if (state_q == NCARP_PUSH) begin
        remain_q <= remain_q - 12'd1;
        column_q <= column_q + 12'd1;
      end
    end
  end

  // Pin drive decode; only read opcodes are ever placed on the port,
  // so program, column move, copy, erase and ID codes never go out
  wire wr_low   = strobe_state && (phase_q == NCARP_PH_PULSE);
  wire in_cmd   = (state_q == NCARP_CMD) || (state_q == NCARP_CONFIRM);
  assign io_out = (state_q == NCARP_CMD)     ? `NCARP_OP_READ
                : (state_q == NCARP_CONFIRM) ? `NCARP_OP_READ_GO
                : addr_q[7:0];
  // Host releases the port whenever it is not writing
  assign io_oe_b_out        = !strobe_state;
  assign chip_sel_n_out     = (state_q == NCARP_IDLE);
  assign cmd_latch_out      = in_cmd;
  assign addr_latch_out     = (state_q == NCARP_ADDR);
  assign write_strobe_n_out = !wr_low;
  assign read_strobe_n_out  = !(state_q == NCARP_READ && !buf_full);
  // Read only sequencer: guard held low keeps the array safe
  assign prog_guard_n_out   = 1'b0;
  assign req_ready_out      = (state_q == NCARP_IDLE);
  assign busy_out           = (state_q != NCARP_IDLE) || !buf_empty;

endmodule : ncarp_host
`default_nettype wire

// ---- testbench/ncarp_flash_model.sv ----
/* Page flash model behind the host sequencer's pins.
   Assumes the bench adds the ready/busy pull-up and resolves the port. */
`timescale 1ns/10ps
`default_nettype none
module ncarp_flash_model (
  // Host pins
  input  wire logic        ce_n_in,
  input  wire logic        cle_in,
  input  wire logic        ale_in,
  input  wire logic        we_n_in,
  input  wire logic        re_n_in,
  input  wire logic        guard_n_in,
  input  wire logic [7:0]  io_in,
  // Array transfer time in ns, never zero
  input  wire logic [15:0] busy_ns_in,
  // Device outputs
  output logic             rb_low_out,
  output logic [7:0]       dq_out,
  output logic             bad_out
);
  logic [7:0]  cmd_q;
  logic [7:0]  ab_q [5];
  logic [2:0]  n_q;
  logic [11:0] col_q;
  // Contents mix column and row so a wrong address shows in the data
  function automatic logic [7:0] pat(input logic [11:0] c,
                                     input logic [16:0] r);
    return c[7:0] + {c[11:8], 4'h3} + (r[7:0] ^ r[15:8] ^ {7'h00, r[16]}) * 8'h05;
  endfunction : pat
  // Power-on state already holds the read opcode
  initial begin
    {cmd_q, n_q, col_q, rb_low_out, bad_out} = '0;
    dq_out = 8'h5a;
  end
  // Guard only gates program and erase, which never run here
  // Rising write strobe latches; deselected strobes do nothing
  always @(posedge we_n_in) begin
    if (rb_low_out && !ce_n_in) bad_out <= 1'b1;
    else if (!ce_n_in && cle_in) begin
      cmd_q <= io_in;
      n_q <= 3'h0;
      if (io_in == 8'h30) begin
        if (cmd_q != 8'h00 || n_q != 3'h5) bad_out <= 1'b1;
        col_q <= {ab_q[1][3:0], ab_q[0]};
        rb_low_out <= 1'b1;
        rb_low_out <= #(busy_ns_in) 1'b0;
      end
    end else if (!ce_n_in && ale_in) begin
      ab_q[n_q] <= io_in;
      n_q <= n_q + 3'h1;
      if (n_q > 3'h4 || (n_q == 3'h1 && io_in[7:4] != 4'h0) ||
          (n_q == 3'h4 && io_in[7:1] != 7'h00)) bad_out <= 1'b1;
    end
  end
  // Falling read strobe presents a byte and steps the column
  // Row is 17 bits: 64 pages by 2048 blocks; no standby modelled
  always @(negedge re_n_in)
    if (!ce_n_in && !cle_in && !ale_in && we_n_in) begin
      if (rb_low_out) bad_out <= 1'b1;
      dq_out <= pat(col_q, {ab_q[4][0], ab_q[3], ab_q[2]});
      if (col_q < 12'd2175) col_q <= col_q + 12'h001;
    end
  // Released port shows the inverse, so a late sample is caught
  always @(posedge re_n_in) dq_out <= ~dq_out;
endmodule : ncarp_flash_model
`default_nettype wire

// ---- testbench/ncarp_host_asserts.sv ----
/* Pin and handshake checks for the flash host sequencer.
   Assumes binding to ncarp_host and sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module ncarp_host_asserts (
  // Clock, reset and user side
  input wire logic       clk_in, rst_b_in, req_valid_in, req_ready_out,
  input wire logic       rd_valid_out, rd_ready_in, busy_out,
  input wire logic [7:0] rd_data_out,
  // Flash pins
  input wire logic       chip_sel_n_out, cmd_latch_out, addr_latch_out,
  input wire logic       write_strobe_n_out, read_strobe_n_out,
  input wire logic       prog_guard_n_out, ready_busy_n_in, io_oe_b_out,
  input wire logic [7:0] io_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // One strobed command or masked address byte
  sequence cmd_s(logic [7:0] v);
    !write_strobe_n_out && cmd_latch_out && io_out == v;
  endsequence
  sequence adr_s(logic [7:0] m);
    !write_strobe_n_out && addr_latch_out && (io_out & m) == 8'h00;
  endsequence
  page_read_a: assert property (cmd_s(8'h00) |-> ##3 adr_s(8'h00) ##3
    adr_s(8'hf0) ##3 adr_s(8'h00) ##3 adr_s(8'h00) ##3 adr_s(8'hfe)
    ##3 cmd_s(8'h30)) else $error("page read sequence malformed");
  guard_low_a: assert property (prog_guard_n_out == 1'b0)
    else $error("program guard released");
  we_entry_a: assert property (!write_strobe_n_out |-> !chip_sel_n_out &&
    !io_oe_b_out && read_strobe_n_out && (cmd_latch_out ^ addr_latch_out))
    else $error("write strobe without proper qualifiers");
  we_pulse_a: assert property ($fell(write_strobe_n_out) |->
    $stable(io_out) ##1 (write_strobe_n_out && $stable(io_out)))
    else $error("write strobe pulse or data hold wrong");
  re_bus_a: assert property (!read_strobe_n_out |-> io_oe_b_out &&
    !chip_sel_n_out && !cmd_latch_out && !addr_latch_out && write_strobe_n_out)
    else $error("read strobe with port or latches wrong");
  re_pace_a: assert property ($fell(read_strobe_n_out) |=>
    read_strobe_n_out [*2]) else $error("read strobe paced too fast");
  busy_quiet_a: assert property (!ready_busy_n_in |->
    write_strobe_n_out && read_strobe_n_out)
    else $error("strobe while device busy");
  req_take_a: assert property (req_valid_in && req_ready_out |=>
    !req_ready_out && busy_out && !chip_sel_n_out)
    else $error("request not taken");
  out_hold_a: assert property (rd_valid_out && !rd_ready_in |=>
    rd_valid_out && $stable(rd_data_out)) else $error("output byte lost");
endmodule : ncarp_host_asserts
bind ncarp_host ncarp_host_asserts chk_i (.*);
`default_nettype wire

// ---- testbench/ncarp_host_tb_top.sv ----
/* Self-checking bench: host sequencer against a page flash model.
   Assumes the checker binds itself to the design. */
`timescale 1ns/10ps
`default_nettype none
module ncarp_host_tb_top;
  logic        clk, rst_b, req_v, rd_r, hold;
  logic [10:0] blk;
  logic [5:0]  pg;
  logic [11:0] col, cnt;
  logic [15:0] bsy;
  logic [7:0]  dq, io_o, rd_d;
  logic        req_r, rd_v, busy, ce_n, cle, ale, we_n, re_n, wp_n;
  logic        rb_low, oe_b, bad;
  logic [7:0]  exp_q[$];
  int          n_fail, cmp_count, cyc;
  wire logic       rb_n = !rb_low;          // Pull-up unless held low
  wire logic [7:0] io_i = oe_b ? dq : io_o; // Shared port level
  ncarp_host uut (.clk_in(clk), .rst_b_in(rst_b), .req_valid_in(req_v),
    .req_ready_out(req_r), .req_block_in(blk), .req_page_in(pg),
    .req_column_in(col), .req_count_in(cnt), .rd_valid_out(rd_v),
    .rd_ready_in(rd_r), .rd_data_out(rd_d), .busy_out(busy),
    .chip_sel_n_out(ce_n), .cmd_latch_out(cle), .addr_latch_out(ale),
    .write_strobe_n_out(we_n), .read_strobe_n_out(re_n),
    .prog_guard_n_out(wp_n), .ready_busy_n_in(rb_n), .io_in(io_i),
    .io_out(io_o), .io_oe_b_out(oe_b));
  ncarp_flash_model fm (.ce_n_in(ce_n), .cle_in(cle), .ale_in(ale),
    .we_n_in(we_n), .re_n_in(re_n), .guard_n_in(wp_n), .io_in(io_i),
    .busy_ns_in(bsy), .rb_low_out(rb_low), .dq_out(dq), .bad_out(bad));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [11:0] seen, want);
    cmp_count++;
    if (seen !== want) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, want, seen);
    end
  endtask : chk
  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  // A run needs a few thousand cycles; this only cuts a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      results();
    end
  end
  // Consumer stalls at random, or nearly always to fill the buffer
  always @(negedge clk) rd_r <= hold ? ($urandom % 32 == 0) : ($urandom % 3 != 0);
  always @(posedge clk)
    if (rd_v === 1'b1 && rd_r === 1'b1) begin
      if (exp_q.size() == 0) chk("extra_byte", 12'h001, 12'h000);
      else chk("rd_data", {4'h0, rd_d}, {4'h0, exp_q.pop_front()});
    end
  // Reference bytes stop at the page's last column
  task automatic run(input logic [10:0] b, input logic [5:0] p,
                     input logic [11:0] c, n);
    int k;
    for (int i = 0; i < n && c + i < 2176; i++)
      exp_q.push_back(fm.pat(12'(c + i), {b, p}));
    while (req_r !== 1'b1) @(negedge clk);
    {blk, pg, col, cnt, req_v} = {b, p, c, n, 1'b1};
    @(negedge clk);
    req_v = 1'b0;
    for (k = 0; k < 20000 && busy !== 1'b0; k++) @(negedge clk);
    chk("queue_left", 12'(exp_q.size()), 12'h000);
    chk("model_flags", {11'h000, bad}, 12'h000);
  endtask : run
  initial begin
    {rst_b, req_v, rd_r, hold, blk, pg, col, cnt} = '0;
    n_fail = 0;
    cmp_count = 0;
    cyc = 0;
    bsy = 16'h01f4;
    void'($urandom(32'he6f5_99df));
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    run(11'h7ff, 6'h3f, 12'h000, 12'h006); // All row bits set
    run(11'h000, 6'h00, 12'h86a, 12'h014); // Stops two columns short of page end
    run(11'h123, 6'h15, 12'h010, 12'h000); // Empty count still runs
    hold = 1'b1;
    bsy = 16'h4e20;
    run(11'h456, 6'h2a, 12'h800, 12'h030); // Slow busy, stalling consumer
    hold = 1'b0;
    bsy = 16'h0028;
    repeat (6) run(11'($urandom), 6'($urandom), 12'($urandom % 2176),
                   12'($urandom % 40));
    results();
  end
endmodule : ncarp_host_tb_top
`default_nettype wire
